// ===== stw_cpu_model.sv
// Processor-side model that drives the special function register strobes
module stw_cpu_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_sfr_rdata,
  output logic      [7:0] o_sfr_addr,
  output logic            o_sfr_wr,
  output logic      [7:0] o_sfr_wdata,
  output logic            o_sfr_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sfr_addr  = 8'h00;
    o_sfr_wr    = 1'b0;
    o_sfr_wdata = 8'h00;
    o_sfr_rd    = 1'b0;
  end
  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Released lines show the inverse of the last value, never a stale match
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_sfr_addr  <= a;
    o_sfr_wdata <= d;
    o_sfr_wr    <= 1'b1;
    @(posedge i_mclk);
    o_sfr_wr    <= 1'b0;
    o_sfr_addr  <= ~a;
    o_sfr_wdata <= ~d;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_sfr_addr <= a;
    o_sfr_rd   <= 1'b1;
    @(posedge i_mclk);
    o_sfr_rd   <= 1'b0;
    o_sfr_addr <= ~a;
    #1;
    d = i_sfr_rdata;
  endtask : sfr_read
endmodule : stw_cpu_model

// ===== stw_divider.sv
// Programmable divider that emits one pulse every (divider value + 1) input ticks
module stw_divider #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_tick_in,
  input  wire logic [W-1:0] i_div,
  output logic              o_tick
);
  import stw_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } stw_div_state_t;

  stw_div_state_t state_ff;
  stw_div_state_t nxt_state;

  // ************************************************************
  // Counter
  // ************************************************************
  // The compare is >= so a divider lowered below the running count wraps at once
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.tick = 1'b0;
    if (i_tick_in) begin
      if (state_ff.cnt >= i_div) begin
        nxt_state.cnt  = '0;
        nxt_state.tick = 1'b1;
      end else begin
        nxt_state.cnt = state_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_tick = state_ff.tick;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_tick_on_match: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_tick_in && state_ff.cnt >= i_div) |=> (o_tick && state_ff.cnt == '0))
    else $error("Divider missed its terminal count");

  chk_no_early_tick: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_tick_in || state_ff.cnt < i_div) |=> !o_tick)
    else $error("Divider ticked before its terminal count");

endmodule : stw_divider

// ===== stw_pkg.sv
// Package of offsets, field positions and reset values for the tick and watchdog block
package stw_pkg;

  // ************************************************************
  // Register offsets on the special function register port
  // ************************************************************
  localparam logic [7:0] STW_OFS_MICROSECOND_DIVIDER_DIV = 8'hfb;
  localparam logic [7:0] STW_OFS_MS_LOW   = 8'hfc;
  localparam logic [7:0] STW_OFS_MS_HIGH  = 8'hfd;
  localparam logic [7:0] STW_OFS_HMS_DIV  = 8'hfe;
  localparam logic [7:0] STW_OFS_WDT_CTL  = 8'hff;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [4:0] STW_RST_MICROSECOND_DIVIDER_DIV = 5'h03;
  localparam logic [7:0] STW_RST_MS_LOW   = 8'h9f;
  localparam logic [7:0] STW_RST_MS_HIGH  = 8'h0f;
  localparam logic [7:0] STW_RST_HMS_DIV  = 8'h63;
  localparam logic [7:0] STW_RST_WDT_CTL  = 8'h00;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int STW_MICROSECOND_DIVIDER_W      = 5;
  localparam int STW_MS_W        = 16;
  localparam int STW_HMS_W       = 8;
  localparam int STW_WDT_CNT_W   = 6;
  localparam int STW_BIT_ENABLE  = 7;
  localparam int STW_BIT_DISABLE = 6;
  localparam int STW_BIT_RESTART = 5;
  localparam int STW_TMO_MSB     = 4;

endpackage : stw_pkg

// ===== stw_top.sv
// Tick prescalers and watchdog timer behind the special function register port
// Notes on behaviour
// - Microsecond tick divides system clock by 5-bit divider field plus one.
// - Microsecond tick goes to flash timing as write duration base.
// - Millisecond tick period is high*256 plus low plus one clocks.
// - Millisecond tick goes to flash timing as erase duration base.
// - Hundred-millisecond tick divides millisecond tick by 8-bit value plus one.
// - Writing one then zero to enable bit starts watchdog counting.
// - Writing one then zero to disable bit stops watchdog counting.
// - Writing one then zero to restart bit restarts watchdog counter at zero.
// - Watchdog expires after timeout plus one to plus two hundred-ms ticks.
module stw_top (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_microsecond_divider_tick,
  output logic            o_msec_tick,
  output logic            o_hms_tick,
  output logic            o_wdt_enabled,
  output logic            o_wdt_expire
);
  import stw_pkg::*;

  typedef struct packed {
    logic [STW_MICROSECOND_DIVIDER_W-1:0]    microsecond_divider_div;
    logic [7:0]               ms_low;
    logic [7:0]               ms_high;
    logic [7:0]               hms_div;
    logic [7:0]               wdt_ctl;
    logic                     wdt_en;
    logic [STW_WDT_CNT_W-1:0] wdt_cnt;
    logic                     expire;
    logic [7:0]               rdata;
  } stw_state_t;

  stw_state_t state_ff;
  stw_state_t nxt_state;

  logic                 microsecond_divider_tick;
  logic                 msec_tick;
  logic                 hms_tick;
  logic                 wr_wdt;
  logic                 seq_enable;
  logic                 seq_disable;
  logic                 seq_restart;
  logic [STW_MS_W-1:0]  ms_div;
  logic [7:0]           rd_mux;
  logic [STW_WDT_CNT_W-1:0] wdt_limit;

  // ************************************************************
  // Prescaler chain
  // ************************************************************
  assign ms_div = {state_ff.ms_high, state_ff.ms_low};

  stw_divider #(.W(STW_MICROSECOND_DIVIDER_W)) u_microsecond_divider_div (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_tick_in (1'b1),
    .i_div     (state_ff.microsecond_divider_div),
    .o_tick    (microsecond_divider_tick)
  );

  stw_divider #(.W(STW_MS_W)) u_msec_div (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_tick_in (1'b1),
    .i_div     (ms_div),
    .o_tick    (msec_tick)
  );

  stw_divider #(.W(STW_HMS_W)) u_hms_div (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_tick_in (msec_tick),
    .i_div     (state_ff.hms_div),
    .o_tick    (hms_tick)
  );

  // Flash timing takes these pulses directly
  assign o_microsecond_divider_tick = microsecond_divider_tick;
  assign o_msec_tick = msec_tick;
  assign o_hms_tick  = hms_tick;

  // ************************************************************
  // Write-one-then-zero detection
  // ************************************************************
  // Compared against the stored bit, so a second zero write does nothing
  assign wr_wdt      = i_sfr_wr && (i_sfr_addr == STW_OFS_WDT_CTL);
  assign seq_enable  = wr_wdt && state_ff.wdt_ctl[STW_BIT_ENABLE]
                       && !i_sfr_wdata[STW_BIT_ENABLE];
  assign seq_disable = wr_wdt && state_ff.wdt_ctl[STW_BIT_DISABLE]
                       && !i_sfr_wdata[STW_BIT_DISABLE];
  assign seq_restart = wr_wdt && state_ff.wdt_ctl[STW_BIT_RESTART]
                       && !i_sfr_wdata[STW_BIT_RESTART];

  // Expiry falls on the tick after (timeout + 1) whole ticks have been seen
  assign wdt_limit = {1'b0, state_ff.wdt_ctl[STW_TMO_MSB:0]} + 6'h01;

  // ************************************************************
  // Read multiplexer
  // ************************************************************
  always_comb begin
    if (i_sfr_addr == STW_OFS_MICROSECOND_DIVIDER_DIV) begin
      rd_mux = {3'h0, state_ff.microsecond_divider_div};
    end else if (i_sfr_addr == STW_OFS_MS_LOW) begin
      rd_mux = state_ff.ms_low;
    end else if (i_sfr_addr == STW_OFS_MS_HIGH) begin
      rd_mux = state_ff.ms_high;
    end else if (i_sfr_addr == STW_OFS_HMS_DIV) begin
      rd_mux = state_ff.hms_div;
    end else if (i_sfr_addr == STW_OFS_WDT_CTL) begin
      rd_mux = state_ff.wdt_ctl;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.expire = 1'b0;
    if (i_sfr_rd) begin
      nxt_state.rdata = rd_mux;
    end
    if (i_sfr_wr) begin
      if (i_sfr_addr == STW_OFS_MICROSECOND_DIVIDER_DIV) begin
        nxt_state.microsecond_divider_div = i_sfr_wdata[STW_MICROSECOND_DIVIDER_W-1:0];
      end else if (i_sfr_addr == STW_OFS_MS_LOW) begin
        nxt_state.ms_low = i_sfr_wdata;
      end else if (i_sfr_addr == STW_OFS_MS_HIGH) begin
        nxt_state.ms_high = i_sfr_wdata;
      end else if (i_sfr_addr == STW_OFS_HMS_DIV) begin
        nxt_state.hms_div = i_sfr_wdata;
      end else if (i_sfr_addr == STW_OFS_WDT_CTL) begin
        nxt_state.wdt_ctl = i_sfr_wdata;
      end
    end
    // Disable wins when both sequences complete in the same write
    if (seq_disable) begin
      nxt_state.wdt_en = 1'b0;
    end else if (seq_enable) begin
      nxt_state.wdt_en = 1'b1;
    end
    if (!state_ff.wdt_en || seq_restart) begin
      nxt_state.wdt_cnt = '0;
    end else if (hms_tick) begin
      if (state_ff.wdt_cnt >= wdt_limit) begin
        nxt_state.wdt_cnt = '0;
        nxt_state.expire  = 1'b1;
      end else begin
        nxt_state.wdt_cnt = state_ff.wdt_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff.microsecond_divider_div <= STW_RST_MICROSECOND_DIVIDER_DIV;
      state_ff.ms_low   <= STW_RST_MS_LOW;
      state_ff.ms_high  <= STW_RST_MS_HIGH;
      state_ff.hms_div  <= STW_RST_HMS_DIV;
      state_ff.wdt_ctl  <= STW_RST_WDT_CTL;
      state_ff.wdt_en   <= 1'b0;
      state_ff.wdt_cnt  <= '0;
      state_ff.expire   <= 1'b0;
      state_ff.rdata    <= 8'h00;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sfr_rdata   = state_ff.rdata;
  assign o_wdt_enabled = state_ff.wdt_en;
  assign o_wdt_expire  = state_ff.expire;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_enable_seq: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (seq_enable && !seq_disable) |=> o_wdt_enabled)
    else $error("Enable sequence did not start the watchdog");

  chk_disable_seq: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    seq_disable |=> !o_wdt_enabled)
    else $error("Disable sequence did not stop the watchdog");

  chk_restart_seq: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    seq_restart |=> (state_ff.wdt_cnt == '0) && !o_wdt_expire)
    else $error("Restart sequence did not clear the watchdog counter");

  chk_zero_only_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_wdt && !state_ff.wdt_ctl[STW_BIT_ENABLE] && !o_wdt_enabled) |=> !o_wdt_enabled)
    else $error("Watchdog enabled without a one-then-zero sequence");

  chk_expire_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_wdt_expire |-> ($past(hms_tick) && $past(state_ff.wdt_cnt) >= $past(wdt_limit)))
    else $error("Watchdog expired at the wrong tick count");

  chk_expire_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_wdt_expire |=> !o_wdt_expire)
    else $error("Expiry event lasted more than one cycle");

  chk_expire_enabled: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_wdt_enabled |=> !o_wdt_expire)
    else $error("Watchdog expired while counting was disabled");

  chk_hms_from_ms: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_hms_tick |-> $past(o_msec_tick))
    else $error("Hundred-millisecond tick without a millisecond tick");

endmodule : stw_top

// ===== stw_top_test.sv
// Self-checking bench for the tick prescalers and watchdog
module stw_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import stw_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  sfr_addr, sfr_wdata, o_sfr_rdata;
  logic        sfr_wr, sfr_rd, o_microsecond_divider_tick, o_msec_tick, o_hms_tick;
  logic        o_wdt_enabled, o_wdt_expire;
  int          fail_count = 0;
  int          n_checks = 0;
  int          mirror [5] = '{8'h03, 8'h9f, 8'h0f, 8'h63, 8'h00};
  logic [15:0] lfsr_q = 16'hb170;
  always #20 i_mclk = ~i_mclk;
  stw_cpu_model u_stw_cpu_model (.i_mclk(i_mclk), .i_sfr_rdata(o_sfr_rdata),
    .o_sfr_addr(sfr_addr), .o_sfr_wr(sfr_wr), .o_sfr_wdata(sfr_wdata), .o_sfr_rd(sfr_rd));
  stw_top u_stw_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_wdata(sfr_wdata), .i_sfr_rd(sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .o_microsecond_divider_tick(o_microsecond_divider_tick), .o_msec_tick(o_msec_tick),
    .o_hms_tick(o_hms_tick), .o_wdt_enabled(o_wdt_enabled), .o_wdt_expire(o_wdt_expire));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic bound(input int c);
    if (c >= 5000) begin
      fail_count++;
      finish_test();
    end
  endtask : bound
  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask : step
  function automatic logic tk(input int s);
    return (s == 0) ? o_microsecond_divider_tick : (s == 1) ? o_msec_tick : o_hms_tick;
  endfunction : tk
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Bus fractions above bit 4 of the microsecond divider are not stored
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_stw_cpu_model.sfr_write(a, d);
    if (a >= 8'hfb) mirror[a - 8'hfb] = (a == 8'hfb) ? (d & 8'h1f) : d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    u_stw_cpu_model.sfr_read(a, d);
    check({8'h00, d}, (a >= 8'hfb) ? 16'(mirror[a - 8'hfb]) : 16'h0000, "rdata");
  endtask : rd_chk
  task automatic wait_tick(input int s);
    int c;
    c = 0;
    do begin step(); c++; end while (tk(s) !== 1'b1 && c < 5000);
    bound(c);
  endtask : wait_tick
  task automatic period(input int s, input int exp);
    int c;
    wait_tick(s);
    c = 0;
    do begin step(); c++; end while (tk(s) !== 1'b1 && c < 5000);
    check(16'(c), 16'(exp), "tick period");
  endtask : period
  task automatic expiry(input int tmo);
    int n;
    int c;
    n = 0;
    c = 0;
    while (o_wdt_expire !== 1'b1 && c < 5000) begin
      step();
      c++;
      if (o_hms_tick === 1'b1) n++;
    end
    bound(c);
    check(16'(n >= tmo + 1 && n <= tmo + 2), 16'h0001, "expiry ticks");
    step();
    check({15'h0, o_wdt_expire}, 16'h0000, "expire width");
  endtask : expiry
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int a = 8'hfa; a <= 8'hff; a++) rd_chk(8'(a));
    wr(8'hfa, 8'h55);
    rd_chk(8'hfa);
    wr(8'hfb, 8'hff);
    rd_chk(8'hfb);
    wr(8'hfb, 8'h02);
    wr(8'hfc, 8'h03);
    wr(8'hfd, 8'h00);
    wr(8'hfe, 8'h01);
    period(0, 3);
    period(1, 4);
    period(2, 8);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr(8'hfc, {6'h00, lfsr_q[1:0]} + 8'h02);
      wr(8'hfe, {6'h00, lfsr_q[3:2]});
      rd_chk(8'hfc);
      period(1, mirror[1] + 1);
      period(2, (mirror[1] + 1) * (mirror[3] + 1));
    end
    wr(8'hfc, 8'h03);
    wr(8'hfe, 8'h01);
    wr(8'hff, 8'h82);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0000, "enable early");
    wr(8'hff, 8'h02);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0001, "enabled");
    expiry(2);
    wait_tick(2);
    wait_tick(2);
    wr(8'hff, 8'h22);
    wr(8'hff, 8'h02);
    expiry(2);
    wr(8'hff, 8'h42);
    wr(8'hff, 8'h02);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0000, "disabled");
    wr(8'hff, 8'h02);
    for (int i = 0; i < 60; i++) begin
      step();
      check({15'h0, o_wdt_expire}, 16'h0000, "expire off");
    end
    check({15'h0, o_wdt_enabled}, 16'h0000, "still off");
    // Enable again, then complete enable and disable in one write: disable wins
    wr(8'hff, 8'h82);
    wr(8'hff, 8'h02);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0001, "re-enabled");
    wr(8'hff, 8'hc2);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0001, "held on");
    wr(8'hff, 8'h02);
    step();
    check({15'h0, o_wdt_enabled}, 16'h0000, "disable wins");
    rd_chk(8'hff);
    finish_test();
  end
endmodule : stw_top_test
